// file: sadc_dev.sv
// Overview of operation
// (RULE_01) host holds start low at least minimum width
// (RULE_02) start is taken at next rising conversion edge; the code holds it off while the result buffer is full
// (RULE_03) one conversion takes two conversion clock cycles
// (RULE_04) first edge latches the 8-bit coarse word
// (RULE_05) coarse word held, selector moves to error
// (RULE_06) second edge latches the 8-bit fine word
// (RULE_07) coarse and fine merge by addition, 12 bits
// (RULE_08) overrange flag set above full scale
// (RULE_09) result coded straight binary
// (RULE_10) busy high while converting, result not valid
// (RULE_11) eoc rises with valid result; host latches
// (RULE_12) start low beyond two pulses starts another
// (RULE_13) start held low converts back to back
// (RULE_14) host uses eoc as hold in continuous
// (RULE_15) host may use busy as single-mode hold
// (RULE_16) asynchronous start still gives accurate result
// (RULE_17) tracking allowed once coarse word is latched
// (RULE_18) pace set only by applied conversion clock
// (RULE_19) eoc fall releases track, rise commands hold
// (RULE_20) result stable from eoc rise to replacement
`timescale 1ns/1ps
`default_nettype none
module sadc_fifo
    import sadc_pkg::*;
#(
    parameter int WIDTH = BUF_W,
    parameter int DEPTH = BUF_DEPTH
) (
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int PW = $clog2(DEPTH) + 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic             push;
    logic             pop;

    // full and empty from pointers carrying one wrap bit
    assign in_ready  = (wr_ptr - rd_ptr) != PW'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr[PW-2:0]];

    // write side
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            wr_ptr <= '0;
        else if (push)
            wr_ptr <= wr_ptr + PW'(1);
    end

    // storage
    always_ff @(posedge core_clk)
    begin
        if (push)
            mem[wr_ptr[PW-2:0]] <= in_data;
    end

    // read side
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            rd_ptr <= '0;
        else if (pop)
            rd_ptr <= rd_ptr + PW'(1);
    end
endmodule

module sadc_dev (
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    sadc_link_if.dev                    link,
    input  wire logic [sadc_pkg::PASS_W-1:0] flash_code,
    output logic                        quantizer_input_selector,
    output logic [sadc_pkg::PASS_W-1:0] coarse_word,
    output logic                        sh_track
);
    import sadc_pkg::*;

    sadc_seq_type         state;
    logic                 clk_prev;
    logic                 clk_rise;
    logic                 pending;
    logic [PASS_W-1:0]    fine_word;
    logic [SUM_W-1:0]     sum;
    logic [SUM_W-1:0]     corrected;
    logic                 over_range;
    logic                 buf_in_valid;
    logic                 buf_in_ready;
    logic [BUF_W-1:0]     buf_out;
    logic                 buf_out_valid;
    logic                 buf_pop;
    logic                 eoc_q;
    logic                 coarse_take;
    logic                 fine_take;

    // conversion clock edge: the pace comes only from the applied clock
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            clk_prev <= 1'b0;
        else
            clk_prev <= link.conv_clk;
    end
    assign clk_rise = link.conv_clk && !clk_prev; // RULE_18

    // a coarse pass only starts when the buffer can take its result
    assign coarse_take = clk_rise && pending && state != SEQ_FINE && buf_in_ready; // RULE_02
    assign fine_take   = clk_rise && state == SEQ_FINE;

    // request flag: low start is remembered until a rising edge takes it as the coarse latch
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            pending <= 1'b0;
        else if (!link.start_n)
            pending <= 1'b1; // RULE_12 RULE_13 RULE_16
        else if (coarse_take)
            pending <= 1'b0;
    end

    // sequencer: idle, coarse pass, fine pass; two conversion edges in all
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            state <= SEQ_IDLE;
        else
        begin
            unique case (state)
                SEQ_IDLE:
                    if (coarse_take)
                        state <= SEQ_FINE; // RULE_02
                    else if (pending)
                        state <= SEQ_COARSE;
                SEQ_COARSE:
                    if (coarse_take)
                        state <= SEQ_FINE; // RULE_03
                SEQ_FINE:
                    if (fine_take)
                        state <= (pending || !link.start_n) ? SEQ_COARSE : SEQ_IDLE; // RULE_13
                default:
                    state <= SEQ_IDLE;
            endcase
        end
    end

    // coarse word held for the subtracting converter; selector flips to error path
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            coarse_word              <= PASS_RST;
            quantizer_input_selector <= 1'b0;
        end
        else if (coarse_take)
        begin
            coarse_word              <= flash_code;  // RULE_04
            quantizer_input_selector <= 1'b1;        // RULE_05
        end
        else if (fine_take)
            quantizer_input_selector <= 1'b0;
    end

    // fine word held for the correction stage
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            fine_word <= PASS_RST;
        else if (fine_take)
            fine_word <= flash_code; // RULE_06
    end

    // sample/hold may track from the coarse latch to the end of the fine pass
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            sh_track <= 1'b0;
        else if (coarse_take)
            sh_track <= 1'b1; // RULE_17
        else if (fine_take)
            sh_track <= 1'b0;
    end

    // result pushed into the buffer one cycle after the fine latch
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            buf_in_valid <= 1'b0;
        else
            buf_in_valid <= fine_take;
    end

    // correction: coarse scaled up plus fine, less the overlap bias, clamped at zero
    always_comb
    begin
        sum = (SUM_W'(coarse_word) << COARSE_SHIFT) + SUM_W'(fine_word); // RULE_07
        if (sum < FINE_BIAS)
            corrected = '0; // RULE_09
        else
            corrected = sum - FINE_BIAS;
        over_range = corrected >= FULL_SCALE; // RULE_08
    end

    sadc_fifo #(
        .WIDTH (BUF_W),
        .DEPTH (BUF_DEPTH)
    ) u_result_buf (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .in_data   ({over_range, corrected[RESULT_W-1:0]}),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .out_data  (buf_out),
        .out_valid (buf_out_valid),
        .out_ready (buf_pop)
    );

    // a word leaves only with eoc low and the host ready, giving one eoc rise per word
    assign buf_pop = buf_out_valid && link.latch_ready && !eoc_q;

    // eoc: rises with a new word, falls at the next coarse latch or when another word waits
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            eoc_q <= 1'b0;
        else if (buf_pop)
            eoc_q <= 1'b1; // RULE_11
        else if (coarse_take || buf_out_valid)
            eoc_q <= 1'b0; // RULE_19
    end
    assign link.eoc = eoc_q;

    // result pins change only when a word leaves the buffer
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            link.result              <= RESULT_RST;
            link.over_full_scale_pin <= 1'b0;
        end
        else if (buf_pop)
        begin
            link.result              <= buf_out[RESULT_W-1:0]; // RULE_20
            link.over_full_scale_pin <= buf_out[RESULT_W];
        end
    end

    // busy from request until the last pass of a run
    assign link.busy = pending || state != SEQ_IDLE; // RULE_10 RULE_12
endmodule
`default_nettype wire

// file: sadc_host.sv
`timescale 1ns/1ps
`default_nettype none
module sadc_host (
    input  wire logic                     core_clk,
    input  wire logic                     sys_rst,
    sadc_link_if.host                     link,
    input  wire logic                     start_req,
    input  wire logic                     cont_mode,
    input  wire logic                     user_ready,
    output logic [sadc_pkg::RESULT_W-1:0] data_word,
    output logic                          data_over,
    output logic                          data_valid,
    output logic                          sh_hold
);
    import sadc_pkg::*;

    logic [CNT_W-1:0] div_cnt;
    logic             conv_clk_q;
    logic [CNT_W-1:0] start_cnt;
    logic             eoc_prev;

    // conversion clock: divided square wave, never above the maximum rate
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            div_cnt    <= '0;
            conv_clk_q <= 1'b0;
        end
        else if (div_cnt == CNT_W'(CONV_HALF_CYC - 1))
        begin
            div_cnt    <= '0;
            conv_clk_q <= !conv_clk_q;
        end
        else
            div_cnt <= div_cnt + CNT_W'(1);
    end
    assign link.conv_clk = conv_clk_q;

    // start pulse of at least the minimum width, or held low in continuous mode
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            start_cnt <= '0;
        else if (start_req)
            start_cnt <= CNT_W'(START_MIN_CYC); // RULE_01
        else if (start_cnt != '0)
            start_cnt <= start_cnt - CNT_W'(1);
    end
    assign link.start_n     = !(cont_mode || start_cnt != '0);
    assign link.latch_ready = user_ready;

    // capture the result on the rising eoc edge
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            eoc_prev   <= 1'b0;
            data_word  <= RESULT_RST;
            data_over  <= 1'b0;
            data_valid <= 1'b0;
        end
        else
        begin
            eoc_prev   <= link.eoc;
            data_valid <= link.eoc && !eoc_prev; // RULE_11
            if (link.eoc && !eoc_prev)
            begin
                data_word <= link.result;
                data_over <= link.over_full_scale_pin;
            end
        end
    end

    // sample/hold command: eoc in continuous mode, busy in single mode
    assign sh_hold = cont_mode ? link.eoc : link.busy; // RULE_14 RULE_15
endmodule
`default_nettype wire

// file: sadc_link_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sadc_link_chk (
    input wire logic                          core_clk,
    input wire logic                          sys_rst,
    input wire logic                          conv_clk,
    input wire logic                          start_n,
    input wire logic                          busy,
    input wire logic                          eoc,
    input wire logic [sadc_pkg::RESULT_W-1:0] result,
    input wire logic                          over_full_scale_pin,
    input wire logic                          latch_ready
);
    import sadc_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // two words eight cycles apart while start is held low and the host keeps taking words
    sequence run_s;
        $rose(eoc) ##1 (!$rose(eoc) && !start_n && latch_ready) [*7] ##1 ($rose(eoc) && !start_n && latch_ready);
    endsequence
    // a fresh request from idle
    sequence idle_req_s;
        $fell(start_n) && !busy && !eoc && latch_ready;
    endsequence
    busy_on_start_a: assert property (!start_n |=> busy)
        else $error("busy low after start");
    busy_idle_a: assert property (!busy && start_n |=> !busy)
        else $error("busy rose without start");
    conv_square_a: assert property ($rose(conv_clk) |-> ##1 conv_clk ##1 !conv_clk [*2] ##1 conv_clk)
        else $error("conversion clock not square");
    first_word_a: assert property (idle_req_s |-> !eoc [*6] ##[1:8] eoc)
        else $error("latency after start out of range");
    busy_then_eoc_a: assert property ($fell(busy) && latch_ready && !eoc |-> ##[1:3] $rose(eoc))
        else $error("no eoc after busy fell");
    back_to_back_a: assert property (run_s ##1 (!start_n && latch_ready) [*7] |=> $rose(eoc))
        else $error("continuous words not eight cycles apart");
    result_hold_a: assert property (!$stable({over_full_scale_pin, result}) |-> eoc)
        else $error("result changed without eoc");
    stall_hold_a: assert property (!latch_ready |=> $stable(result) && $stable(over_full_scale_pin))
        else $error("result changed during stall");
    eoc_ready_a: assert property ($rose(eoc) |-> $past(latch_ready))
        else $error("eoc rose while host not ready");
endmodule
`default_nettype wire

// file: sadc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sadc_link_if;
    import sadc_pkg::*;
    logic                conv_clk;
    logic                start_n;
    logic                busy;
    logic                eoc;
    logic [RESULT_W-1:0] result;
    logic                over_full_scale_pin;
    logic                latch_ready;
    modport dev  (input conv_clk, start_n, latch_ready, output busy, eoc, result, over_full_scale_pin);
    modport host (output conv_clk, start_n, latch_ready, input busy, eoc, result, over_full_scale_pin);
endinterface
`default_nettype wire

// file: sadc_pkg.sv
`default_nettype none
package sadc_pkg;
    // widths of the pass words and the merged result
    localparam int PASS_W   = 8;
    localparam int RESULT_W = 12;
    localparam int SUM_W    = 14;
    // the coarse word lands 4 bits up; the fine word carries a mid-scale bias for overlap correction
    localparam int              COARSE_SHIFT = 4;
    localparam logic [SUM_W-1:0] FINE_BIAS   = 14'h0080;
    localparam logic [SUM_W-1:0] FULL_SCALE  = 14'h1000;
    // reset values of the result pins and the pass words
    localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
    localparam logic [PASS_W-1:0]   PASS_RST   = 8'h00;
    // core clock and link timing
    localparam int CORE_CLK_NS     = 100;
    localparam int START_MIN_NS    = 50;
    localparam int CONV_CLK_MIN_NS = 250;
    localparam int START_MIN_CYC   = (START_MIN_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
    localparam int CONV_HALF_CYC   = (CONV_CLK_MIN_NS / 2 + CORE_CLK_NS - 1) / CORE_CLK_NS;
    localparam int CNT_W           = 4;
    // two-entry result buffer
    localparam int BUF_DEPTH = 2;
    localparam int BUF_W     = RESULT_W + 1;
    // sequencer states
    typedef enum logic [2:0] {
        SEQ_IDLE   = 3'b001,
        SEQ_COARSE = 3'b010,
        SEQ_FINE   = 3'b100
    } sadc_seq_type;
endpackage
`default_nettype wire

// file: test_subranging_adc_conversion_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_subranging_adc_conversion_sequencer;
    import sadc_pkg::*;
    logic                core_clk = 1'b0;
    logic                sys_rst = 1'b1;
    logic [PASS_W-1:0]   flash_code = 8'h00;
    logic                start_req = 1'b0;
    logic                cont_mode = 1'b0;
    logic                user_ready = 1'b1;
    logic                sel, track, sh_hold, dvalid, dover;
    logic [PASS_W-1:0]   coarse;
    logic [RESULT_W-1:0] dword;
    logic [31:0]         rng = 32'h56044A16;
    logic [31:0]         rs = 32'h56044A16;
    logic                cc_q = 1'b0;
    logic                armed = 1'b0;
    logic [PASS_W-1:0]   last_fl = 8'h00;
    logic [PASS_W-1:0]   tbl [8] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h08, 8'h80, 8'h10, 8'h7F};
    logic [12:0]         exp_q [$];
    int                  fail_count = 0;
    int                  n_tests = 0;
    int                  fl_idx = 0;
    int                  v;
    sadc_link_if link ();
    sadc_dev u_sadc_dev (.core_clk(core_clk), .sys_rst(sys_rst), .link(link.dev), .flash_code(flash_code),
        .quantizer_input_selector(sel), .coarse_word(coarse), .sh_track(track));
    sadc_host u_sadc_host (.core_clk(core_clk), .sys_rst(sys_rst), .link(link.host), .start_req(start_req),
        .cont_mode(cont_mode), .user_ready(user_ready), .data_word(dword), .data_over(dover),
        .data_valid(dvalid), .sh_hold(sh_hold));
    sadc_link_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .conv_clk(link.conv_clk),
        .start_n(link.start_n), .busy(link.busy), .eoc(link.eoc), .result(link.result),
        .over_full_scale_pin(link.over_full_scale_pin), .latch_ready(link.latch_ready));
    // core clock, 100 ns period
    always #50 core_clk = ~core_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic check(input string what, input logic [12:0] seen, input logic [12:0] want);
        n_tests++;
        if (seen !== want)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic ticks(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // new quantizer word once per conversion clock period, corner table first
    always @(negedge core_clk)
    begin
        if (link.conv_clk)
            armed = 1'b1;
        else if (armed)
        begin
            armed = 1'b0;
            rng = xs(rng);
            flash_code = (fl_idx < 8) ? tbl[fl_idx] : rng[7:0];
            fl_idx++;
        end
    end
    // reference model: pairs the two passes and checks every host word
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            exp_q.delete();
            cc_q = 1'b0;
        end
        else
        begin
            if (link.conv_clk && !cc_q)
            begin
                if (sel)
                begin
                    check("coarse_word", {5'h00, coarse}, {5'h00, last_fl});
                    v = last_fl * 16 + flash_code - 128;
                    if (v < 0)
                        v = 0;
                    exp_q.push_back({v >= 4096, v[11:0]});
                end
                last_fl = flash_code;
            end
            cc_q = link.conv_clk;
            check("sh_hold", {12'h000, sh_hold}, {12'h000, cont_mode ? link.eoc : link.busy});
            check("sh_track", {12'h000, track}, {12'h000, sel});
            if (dvalid)
                check("data_word", {dover, dword}, exp_q.size() > 0 ? exp_q.pop_front() : 13'h1FFF);
        end
    end
    // stimulus: single requests, continuous run with stalls, reset mid conversion
    initial
    begin
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 30; i++)
        begin
            rs = xs(rs);
            start_req = 1'b1;
            ticks(1);
            start_req = 1'b0;
            ticks(rs[3:0] + 1);
        end
        ticks(20);
        cont_mode = 1'b1;
        ticks(40);
        for (int i = 0; i < 80; i++)
        begin
            rs = xs(rs);
            user_ready = (i < 30) ? 1'b0 : rs[0];
            ticks(1);
        end
        user_ready = 1'b1;
        ticks(20);
        cont_mode = 1'b0;
        ticks(30);
        check("drained", 13'(exp_q.size()), 13'h0000);
        start_req = 1'b1;
        ticks(1);
        start_req = 1'b0;
        ticks(5);
        sys_rst = 1'b1;
        ticks(2);
        sys_rst = 1'b0;
        ticks(1);
        check("reset_word", {dover, dword}, 13'h0000);
        check("reset_busy", {12'h000, link.busy}, 13'h0000);
        start_req = 1'b1;
        ticks(1);
        start_req = 1'b0;
        ticks(30);
        check("final_drain", 13'(exp_q.size()), 13'h0000);
        give_verdict();
    end
    // watchdog: about forty times the expected run
    initial
    begin
        #2000000;
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
